// File: arr_defines.vh
// Constants shared by the cell reassembly block and its submodules.
// Assumes inclusion by bare name from files in the same folder.
`ifndef ARR_DEFINES_VH
`define ARR_DEFINES_VH

// Matrix geometry: 128 columns by 47 rows, one column per cell
`define ARR_LAST_ROW 6'h2E
`define ARR_LAST_COL 7'h7F
// Last information octet of a 128-octet row (124 data + 4 check)
`define ARR_LAST_INFO 7'h7B

// Header check: x^3 + x + 1 without its top term
`define ARR_CRC_POLY 3'h3
// Count jump that marks a cell as mis-inserted
`define ARR_MISINSERT 3'h7
// Value written for each octet of a lost cell
`define ARR_DUMMY 8'h00

// Galois field for row decoding: x^8+x^4+x^3+x^2+1, low byte
`define ARR_GF_POLY 8'h1D
`define ARR_ALPHA 8'h02
`define ARR_ALPHA2 8'h04
`define ARR_ALPHA3 8'h08
`define ARR_ALPHA_INV 8'h8E

// Adaptive service clock: starting tick period and fill target
`define ARR_TICK_INIT 16'h0010
`define ARR_TICK_MAX 16'hFFFF
`define ARR_CREDIT_TARGET 8'h40
`define ARR_CREDIT_MAX 8'hFF

`endif

// File: arr_header_check.v
// Header octet check: splits sequence count and CSI, checks CRC-3 and
// parity. Purely combinational; the caller samples the results.
`timescale 1ns/1ns
`include "arr_defines.vh"

module arr_header_check
(
    // Header octet
    input wire [7:0] hdr,
    // Decoded fields
    output reg [2:0] sc,
    output reg csi,
    output reg sn_ok
);

reg [2:0] rem;
reg fb;
integer i;

always @*
begin
    rem = 3'h0;
    fb = 1'b0;
    // Remainder of x^3 times the 4-bit sequence number field
    for (i = 3; i >= 0; i = i - 1)
    begin
        fb = hdr[4 + i] ^ rem[2];
        rem = {rem[1:0], 1'b0} ^ (fb ? `ARR_CRC_POLY : 3'h0);
    end
    csi = hdr[7];
    sc = hdr[6:4];
    // Even parity over all eight bits means the XOR is zero
    sn_ok = (rem == hdr[3:1]) && !(^hdr);
end

endmodule

// File: arr_row_decoder.v
// Row decoder for 128-octet codewords with four check octets.
// Pass one feeds a row for syndromes; a 128-cycle search follows;
// during the second feed fix_data gives the corrected octet.
// Handles one error or one erasure per row; more is flagged bad.
`timescale 1ns/1ns
`include "arr_defines.vh"

module arr_row_decoder
(
    // Clock and reset
    input wire clock,
    input wire rst_b,
    // Syndrome pass
    input wire in_valid,
    input wire in_first,
    input wire in_last,
    input wire [7:0] in_data,
    input wire in_erase,
    // Output pass
    input wire [6:0] out_idx,
    output wire [7:0] fix_data,
    // Result
    output reg done,
    output reg row_bad
);

function [7:0] gf_mul(input [7:0] a, input [7:0] b);
    reg [7:0] p;
    reg [7:0] x;
    integer n;
    begin
        p = 8'h00;
        x = a;
        for (n = 0; n < 8; n = n + 1)
        begin
            if (b[n])
                p = p ^ x;
            x = x[7] ? ({x[6:0], 1'b0} ^ `ARR_GF_POLY) : {x[6:0], 1'b0};
        end
        gf_mul = p;
    end
endfunction

reg [7:0] s0, s1, s2, s3, p, w;
reg [6:0] k, pos, epos;
reg [1:0] ecount;
reg srch, found, have_fix;

wire match = gf_mul(s0, w) == s1;
wire zero = (s0 | s1 | s2 | s3) == 8'h00;
wire single = (s0 != 8'h00) && (gf_mul(s1, s1) == gf_mul(s0, s2))
    && (gf_mul(s2, s2) == gf_mul(s1, s3));
wire found_now = found | match;
wire [6:0] pos_now = found ? pos : k;
// An erased octet must be the located one, else we cannot trust it
wire fix_ok = single && found_now && ((ecount == 2'h0)
    || ((ecount == 2'h1) && (pos_now == epos)));

assign fix_data = in_data ^ ((have_fix && out_idx == pos) ? s0 : 8'h00);

always @(posedge clock)
begin
    if (!rst_b)
    begin
        s0 <= 8'h00;
        s1 <= 8'h00;
        s2 <= 8'h00;
        s3 <= 8'h00;
        p <= 8'h01;
        w <= 8'h00;
        k <= 7'h00;
        pos <= 7'h00;
        epos <= 7'h00;
        ecount <= 2'h0;
        srch <= 1'b0;
        found <= 1'b0;
        have_fix <= 1'b0;
        done <= 1'b0;
        row_bad <= 1'b0;
    end
    else
    begin
        done <= 1'b0;
        if (in_valid)
        begin
            if (in_first)
            begin
                s0 <= in_data;
                s1 <= in_data;
                s2 <= in_data;
                s3 <= in_data;
                p <= 8'h01;
                ecount <= in_erase ? 2'h1 : 2'h0;
                epos <= 7'h00;
            end
            else
            begin
                s0 <= s0 ^ in_data;
                s1 <= gf_mul(s1, `ARR_ALPHA) ^ in_data;
                s2 <= gf_mul(s2, `ARR_ALPHA2) ^ in_data;
                s3 <= gf_mul(s3, `ARR_ALPHA3) ^ in_data;
                p <= gf_mul(p, `ARR_ALPHA);
                if (in_erase && ecount != 2'h2)
                    ecount <= ecount + 2'h1;
                if (in_erase && ecount == 2'h0)
                    epos <= out_idx;
            end
            if (in_last)
            begin
                srch <= 1'b1;
                k <= 7'h00;
                found <= 1'b0;
                w <= gf_mul(p, `ARR_ALPHA);
            end
        end
        else if (srch)
        begin
            if (!found && match)
                pos <= k;
            found <= found_now;
            w <= gf_mul(w, `ARR_ALPHA_INV);
            k <= k + 7'h01;
            if (k == `ARR_LAST_COL)
            begin
                pos <= pos_now;
                srch <= 1'b0;
                done <= 1'b1;
                have_fix <= !zero && fix_ok;
                row_bad <= !zero && !fix_ok;
            end
        end
    end
end

endmodule

// File: arr_receive_reassembly.v
// Receive reassembly: cell payloads in, status-tagged octets out.
// Assumes the upstream block holds octets while cell_ready is low
// and marks each header octet with cell_start.
//
// How it works
// - Strip header octet, keep 47 payload octets
// - Header check yields count, CSI, status
// - Invalid header status raises management event
// - Deliver single octets with valid/invalid status
// - Invalid status only for uncorrected errors
// - Count jumps insert 47 dummy octets per loss
// - Mis-inserted cells dropped without further work
// - Lost or mis-inserted cells reported to management
// - Service clock recovered from received data rate
// - Payloads written into matrix column by column
// - Dummy octets carry an erasure mark
// - Rows read to decoder after matrix fills
// - Decoder corrects erasures and errored octets
// - Uncorrectable rows flagged to stream and management
// - Matrix holds 128 columns of 47 rows
// - CSI set marks the first matrix payload
// - Header protected by CRC-3 and parity
`timescale 1ns/1ns
`include "arr_defines.vh"

module arr_receive_reassembly
#(
    parameter TICK_INIT = `ARR_TICK_INIT,
    parameter CREDIT_TARGET = `ARR_CREDIT_TARGET
)
(
    // Clock and reset
    input wire clock,
    input wire rst_b,
    // Cell payload octets from the virtual path block
    input wire [7:0] cell_data,
    input wire cell_valid,
    input wire cell_start,
    output reg cell_ready,
    // Management control
    input wire monitored_state,
    // Octets toward the transport stream interface block
    output reg [7:0] sdu_data,
    output reg sdu_valid,
    output reg sdu_status_ok,
    output reg service_clock_tick,
    // Events toward the equipment management function
    output reg sequence_number_invalid_event,
    output reg lost_misinserted_cell_event,
    output reg rs_uncorrectable_event
);

localparam S_HDR = 6'h01;
localparam S_DATA = 6'h02;
localparam S_FILL = 6'h04;
localparam S_SYN = 6'h08;
localparam S_OUT = 6'h10;
localparam S_SRCH = 6'h20;

reg [5:0] state;
reg [5:0] next_state;
reg [5:0] row;
reg [6:0] col;
reg [2:0] expected;
reg [2:0] lost;
reg synced;
reg [7:0] matrix [0:6015];
reg erased [0:6015];
reg [15:0] period;
reg [15:0] tcount;
reg [7:0] credit;
reg waiting;

wire [2:0] hc_sc;
wire hc_csi;
wire hc_ok;
wire [7:0] dec_fix;
wire dec_done;
wire dec_bad;

arr_header_check u_hdr
(
    .hdr(cell_data),
    .sc(hc_sc),
    .csi(hc_csi),
    .sn_ok(hc_ok)
);

wire [12:0] idx = {row, col};
wire [7:0] rd_data = matrix[idx];
wire rd_erase = erased[idx];
wire take = cell_valid & cell_ready;
wire hdr_take = state[0] & take & cell_start;
// A failed header is taken as carrying the expected count
wire [2:0] sc_eff = hc_ok ? hc_sc : expected;
wire [2:0] delta = sc_eff - expected;
wire resync = hc_ok & hc_csi;
wire go_data = resync | (synced & (delta == 3'h0));
wire go_mis = !resync & synced & (delta == `ARR_MISINSERT);
wire go_fill = !resync & synced & !go_mis & (delta != 3'h0);
wire row_end = row == `ARR_LAST_ROW;
wire col_end = col == `ARR_LAST_COL;
wire put_data = state[1] & take;
wire put_any = put_data | state[2];
wire feed = state[3];
wire tick_now = tcount >= period;

arr_row_decoder u_dec
(
    .clock(clock),
    .rst_b(rst_b),
    .in_valid(feed),
    .in_first(col == 7'h00),
    .in_last(col_end),
    .in_data(rd_data),
    .in_erase(rd_erase),
    .out_idx(col),
    .fix_data(dec_fix),
    .done(dec_done),
    .row_bad(dec_bad)
);

always @*
begin
    next_state = state;
    case (state)
        S_HDR:
        begin
            if (hdr_take && go_data)
                next_state = S_DATA;
            else if (hdr_take && go_fill)
                next_state = S_FILL;
        end
        S_DATA:
        begin
            if (put_data && row_end)
                next_state = col_end ? S_SYN : S_HDR;
        end
        S_FILL:
        begin
            if (row_end && col_end)
                next_state = S_SYN;
            else if (row_end && lost == 3'h1)
                next_state = S_DATA;
        end
        S_SYN:
        begin
            if (col_end)
                next_state = S_SRCH;
        end
        S_SRCH:
        begin
            if (waiting && dec_done)
                next_state = S_OUT;
        end
        S_OUT:
        begin
            if (col == `ARR_LAST_INFO)
                next_state = row_end ? S_HDR : S_SYN;
        end
        default:
            next_state = S_HDR;
    endcase
end

// Ready stays low on the edge that ends readout, so no octet is
// taken while the last delivered octet is still on the outputs
always @(posedge clock)
begin
    if (!rst_b)
    begin
        state <= S_HDR;
        waiting <= 1'b0;
        cell_ready <= 1'b1;
    end
    else
    begin
        state <= next_state;
        waiting <= (next_state == S_SRCH);
        cell_ready <= ((next_state == S_HDR) || (next_state == S_DATA))
            && (state != S_OUT);
    end
end

// Matrix storage has no reset; every cell is rewritten each matrix
always @(posedge clock)
begin
    if (put_any)
    begin
        matrix[idx] <= state[2] ? `ARR_DUMMY : cell_data;
        erased[idx] <= state[2];
    end
end

always @(posedge clock)
begin
    if (!rst_b)
    begin
        row <= 6'h00;
        col <= 7'h00;
        expected <= 3'h0;
        lost <= 3'h0;
        synced <= 1'b0;
        sdu_data <= 8'h00;
        sdu_valid <= 1'b0;
        sdu_status_ok <= 1'b1;
        sequence_number_invalid_event <= 1'b0;
        lost_misinserted_cell_event <= 1'b0;
        rs_uncorrectable_event <= 1'b0;
    end
    else
    begin
        sdu_valid <= 1'b0;
        sequence_number_invalid_event <= 1'b0;
        lost_misinserted_cell_event <= 1'b0;
        rs_uncorrectable_event <= 1'b0;
        if (hdr_take)
        begin
            sequence_number_invalid_event <= !hc_ok & monitored_state;
            if (resync)
            begin
                // Restart the matrix; a partial one is abandoned
                row <= 6'h00;
                col <= 7'h00;
                synced <= 1'b1;
                expected <= hc_sc + 3'h1;
            end
            else if (go_data)
                expected <= sc_eff + 3'h1;
            else if (go_fill)
            begin
                lost <= delta;
                expected <= sc_eff + 3'h1;
            end
            // Mis-inserted cell: its payload, lacking a start mark,
            // is swallowed by this state without being stored
            if (go_mis || go_fill)
                lost_misinserted_cell_event <= monitored_state;
        end
        if (put_any)
        begin
            if (row_end)
            begin
                row <= 6'h00;
                col <= col + 7'h01;
                if (state[2])
                    lost <= lost - 3'h1;
            end
            else
                row <= row + 6'h01;
        end
        if (feed)
            col <= col + 7'h01;
        if (state == S_OUT)
        begin
            sdu_data <= dec_fix;
            sdu_valid <= 1'b1;
            sdu_status_ok <= !dec_bad;
            if (col == 7'h00)
                rs_uncorrectable_event <= dec_bad & monitored_state;
            if (col == `ARR_LAST_INFO)
            begin
                col <= 7'h00;
                row <= row_end ? 6'h00 : row + 6'h01;
            end
            else
                col <= col + 7'h01;
        end
    end
end

// Adaptive clock: octet credit from the incoming flow steers
// the tick period, so no reference clock is needed
always @(posedge clock)
begin
    if (!rst_b)
    begin
        period <= TICK_INIT;
        tcount <= 16'h0000;
        credit <= 8'h00;
        service_clock_tick <= 1'b0;
    end
    else
    begin
        service_clock_tick <= tick_now;
        tcount <= tick_now ? 16'h0000 : tcount + 16'h0001;
        if (put_any && !tick_now && credit != `ARR_CREDIT_MAX)
            credit <= credit + 8'h01;
        else if (tick_now && !put_any && credit != 8'h00)
            credit <= credit - 8'h01;
        if (tick_now)
        begin
            if (credit > CREDIT_TARGET && period > 16'h0001)
                period <= period - 16'h0001;
            else if (credit < CREDIT_TARGET && period != `ARR_TICK_MAX)
                period <= period + 16'h0001;
        end
    end
end

endmodule

// File: arr_cell_source.sv
// Cell source model standing in for the virtual path block.
// Assumes one bench process calls its tasks, at rising edges only.
`timescale 1ns/1ns

module arr_cell_source
(
    // Clock and back-pressure
    input wire clock,
    input wire cell_ready,
    // Cell octets toward the block
    output reg [7:0] cell_data,
    output reg cell_valid,
    output reg cell_start
);
    initial
    begin
        cell_data = 8'h00;
        cell_valid = 1'b0;
        cell_start = 1'b0;
    end

    // Octet held until sampled with ready high
    task put(input [7:0] d, input s);
    begin
        cell_data <= d;
        cell_start <= s;
        cell_valid <= 1'b1;
        @(posedge clock);
        while (cell_ready !== 1'b1)
            @(posedge clock);
    end
    endtask

    // Released bus shows inverted data, never the last value
    task idle;
    begin
        cell_valid <= 1'b0;
        cell_start <= 1'b0;
        cell_data <= ~cell_data;
    end
    endtask

    // Zero payload is a codeword; erow 47 hits all rows, 63 none
    task send_cell(input csi, input [2:0] sc, input bad, input [5:0] erow);
        reg [3:0] sn;
        reg [2:0] r;
        reg [7:0] h;
        integer i;
    begin
        sn = {csi, sc};
        r = 3'h0;
        for (i = 3; i >= 0; i = i - 1)
            r = {r[1:0], 1'b0} ^ ((sn[i] ^ r[2]) ? 3'h3 : 3'h0);
        h = {sn, r, 1'b0};
        h[0] = ^h[7:1] ^ bad;
        put(h, 1'b1);
        for (i = 0; i < 47; i = i + 1)
            put((erow == i || erow == 47) ? 8'hA5 : 8'h00, 1'b0);
    end
    endtask
endmodule

// File: arr_receive_reassembly_checker.sv
// Port checker for the receive reassembly block.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ns

module arr_receive_reassembly_checker
(
    // Clock and reset
    input logic clock,
    input logic rst_b,
    // Cell input
    input logic cell_valid,
    input logic cell_start,
    input logic cell_ready,
    // Control and outputs
    input logic monitored_state,
    input logic sdu_valid,
    input logic sdu_status_ok,
    input logic sequence_number_invalid_event,
    input logic lost_misinserted_cell_event,
    input logic rs_uncorrectable_event
);
    default clocking dc @(posedge clock); endclocking
    default disable iff (!rst_b);

    logic [7:0] run;
    always @(posedge clock)
        run <= (!rst_b || !sdu_valid) ? 8'h00 : run + 8'h01;

    sequence hdr_taken;
        cell_valid && cell_ready && cell_start;
    endsequence
    sequence bad_row;
        sdu_valid && !$past(sdu_valid) && !sdu_status_ok && monitored_state;
    endsequence

    chk_sni_cause:
        assert property (sequence_number_invalid_event
            |-> $past(cell_valid && cell_ready && cell_start))
        else $error("header event without a header");
    chk_lmc_cause:
        assert property (lost_misinserted_cell_event
            |-> $past(cell_valid && cell_ready && cell_start))
        else $error("cell event without a header");
    chk_event_gate:
        assert property ((hdr_taken ##0 !monitored_state) ##1 !monitored_state
            |-> !sequence_number_invalid_event && !lost_misinserted_cell_event)
        else $error("event while unmonitored");
    chk_status_steady:
        assert property (sdu_valid && $past(sdu_valid) |-> $stable(sdu_status_ok))
        else $error("status changed inside a row");
    chk_rs_first:
        assert property (rs_uncorrectable_event
            |-> sdu_valid && !sdu_status_ok && !$past(sdu_valid))
        else $error("decoder event off a bad row start");
    chk_bad_row_flag:
        assert property (bad_row |-> rs_uncorrectable_event)
        else $error("bad row without decoder event");
    chk_row_length:
        assert property ($fell(sdu_valid) |-> run == 8'h7C)
        else $error("row burst not 124 octets");
    chk_no_input_readout:
        assert property (sdu_valid |-> !cell_ready)
        else $error("input open during readout");
endmodule

// File: test_arr_receive_reassembly.sv
// Bench for the receive reassembly block fed by a cell source model.
// Assumes all-zero payloads; error octets are A5.
`timescale 1ns/1ns

module test_arr_receive_reassembly;
    reg clock;
    reg rst_b;
    reg monitored_state;
    wire [7:0] cell_data;
    wire [7:0] sdu_data;
    wire cell_valid, cell_start, cell_ready, sdu_valid, sdu_status_ok;
    wire service_clock_tick, sequence_number_invalid_event;
    wire lost_misinserted_cell_event, rs_uncorrectable_event;
    integer err_count = 0, check_count = 0, first_bad = -1;
    integer oct_n = 0, bad_n = 0, dirty_n = 0, rs_n = 0;
    integer sni_n = 0, lmc_n = 0, tick_n = 0;

    arr_cell_source i_arr_cell_source (.clock(clock),
        .cell_ready(cell_ready), .cell_data(cell_data),
        .cell_valid(cell_valid), .cell_start(cell_start));
    arr_receive_reassembly i_arr_receive_reassembly (.clock(clock),
        .rst_b(rst_b), .cell_data(cell_data), .cell_valid(cell_valid),
        .cell_start(cell_start), .cell_ready(cell_ready),
        .monitored_state(monitored_state), .sdu_data(sdu_data),
        .sdu_valid(sdu_valid), .sdu_status_ok(sdu_status_ok),
        .service_clock_tick(service_clock_tick),
        .sequence_number_invalid_event(sequence_number_invalid_event),
        .lost_misinserted_cell_event(lost_misinserted_cell_event),
        .rs_uncorrectable_event(rs_uncorrectable_event));

    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    always @(posedge clock)
    begin
        if (sdu_valid === 1'b1)
        begin
            if (sdu_status_ok !== 1'b1 && first_bad < 0)
                first_bad = oct_n % 5828;
            bad_n = bad_n + (sdu_status_ok !== 1'b1);
            dirty_n = dirty_n + (sdu_status_ok === 1'b1 && sdu_data !== 8'h00);
            oct_n = oct_n + 1;
        end
        rs_n = rs_n + (rs_uncorrectable_event === 1'b1);
        sni_n = sni_n + (sequence_number_invalid_event === 1'b1);
        lmc_n = lmc_n + (lost_misinserted_cell_event === 1'b1);
        tick_n = tick_n + (service_clock_tick === 1'b1);
    end

    task compare(input string what, input integer exp, input integer got);
    begin
        check_count = check_count + 1;
        if (got !== exp)
        begin
            err_count = err_count + 1;
            $display("wrong value %s expected %0d seen %0d", what, exp, got);
        end
    end
    endtask

    // One errored octet in row 0, three (beyond repair) in row 1
    function [5:0] erow(input integer c);
        erow = (c == 5) ? 6'h00 : (c > 5 && c < 9) ? 6'h01 : 6'h3F;
    endfunction

    task send_matrix(input integer lost, mis, badh, input errs);
        integer c;
    begin
        for (c = 0; c < 128; c = c + 1)
        begin
            if (c != lost)
                i_arr_cell_source.send_cell(c == 0, c[2:0], c == badh,
                    errs ? erow(c) : 6'h3F);
            if (c == mis)
                i_arr_cell_source.send_cell(1'b0, c[2:0], 1'b0, 6'h2F);
        end
        i_arr_cell_source.idle;
    end
    endtask

    task wait_out(input integer n);
        integer t;
    begin
        t = 0;
        while (oct_n < n && t < 30000)
        begin
            @(posedge clock);
            t = t + 1;
        end
    end
    endtask

    task test_errors;
        integer t0;
    begin
        t0 = tick_n;
        send_matrix(-1, -1, -1, 1'b1);
        wait_out(5828);
        compare("octets", 5828, oct_n);
        compare("bad octets", 124, bad_n);
        compare("first bad", 124, first_bad);
        compare("unfixed", 0, dirty_n);
        compare("rs events", 1, rs_n);
        compare("sn events", 0, sni_n + lmc_n);
        compare("ticks", 1, tick_n > t0);
        $display("test_errors done");
    end
    endtask

    task test_loss;
        integer l0, s0, b0;
    begin
        l0 = lmc_n;
        s0 = sni_n;
        b0 = bad_n;
        send_matrix(10, 3, 12, 1'b0);
        wait_out(11656);
        compare("octets", 11656, oct_n);
        compare("cell events", l0 + 2, lmc_n);
        compare("sn events", s0 + 1, sni_n);
        compare("bad octets", b0, bad_n);
        compare("unfixed", 0, dirty_n);
        $display("test_loss done");
    end
    endtask

    task test_gate;
        integer s0;
    begin
        s0 = sni_n;
        monitored_state <= 1'b0;
        i_arr_cell_source.send_cell(1'b1, 3'h0, 1'b0, 6'h3F);
        i_arr_cell_source.send_cell(1'b0, 3'h1, 1'b1, 6'h3F);
        i_arr_cell_source.idle;
        repeat (4) @(posedge clock);
        compare("muted events", s0, sni_n);
        monitored_state <= 1'b1;
        i_arr_cell_source.send_cell(1'b0, 3'h2, 1'b1, 6'h3F);
        i_arr_cell_source.idle;
        repeat (4) @(posedge clock);
        compare("sn events", s0 + 1, sni_n);
        $display("test_gate done");
    end
    endtask

    task summarize;
    begin
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask

    initial
    begin
        #(70000 * 100);
        err_count = err_count + 1;
        $display("watchdog expired");
        summarize;
    end

    initial
    begin
        rst_b = 1'b0;
        monitored_state = 1'b1;
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        test_errors;
        test_loss;
        test_gate;
        summarize;
    end
endmodule

bind arr_receive_reassembly arr_receive_reassembly_checker
    i_arr_receive_reassembly_checker (.clock(clock), .rst_b(rst_b),
    .cell_valid(cell_valid), .cell_start(cell_start),
    .cell_ready(cell_ready), .monitored_state(monitored_state),
    .sdu_valid(sdu_valid), .sdu_status_ok(sdu_status_ok),
    .sequence_number_invalid_event(sequence_number_invalid_event),
    .lost_misinserted_cell_event(lost_misinserted_cell_event),
    .rs_uncorrectable_event(rs_uncorrectable_event));
